//--- btf_unit.sv
// How it works
// - Texels come live from the attached store
// - One data store, no detail levels
// - Name zero detaches, zeroes offset and size
// - Unknown format gives bad enum error
// - Unknown nonzero name gives bad operation error
// - Bad offset, size or range: bad value
// - Misaligned offset gives bad value error
// - Whole attach: offset zero, full length
// - Texel count is size over texel bytes
// - Texel count clamped to maximum limit
// - Element m of texel n at n*comps+m
// - Elements decoded by format base type
// - Only unsigned normalized formats get normalized
// - Normalized values use fixed point conversion
// - Missing green, blue read 0; alpha 1
// - Three components only in 32-bit formats
// - Result type follows the format class
// - Store binding point never alters attachment
module btf_unit (
    // Clock and reset
    input  logic                  clk_i,
    input  logic                  rst_i,
    // Attach commands
    input  logic                  att_valid_i,
    input  btf_pkg::btf_att_cmd_s att_cmd_i,
    output logic                  att_done_o,
    output btf_pkg::btf_err_e     att_err_o,
    output btf_pkg::btf_bind_s    bind_state_o,
    // Store binding point
    input  logic                  bind_store_valid_i,
    input  logic [31:0]           bind_store_name_i,
    // Texel fetches
    input  logic                  fetch_valid_i,
    input  logic [31:0]           fetch_coord_i,
    output logic                  fetch_ready_o,
    output logic                  result_valid_o,
    output btf_pkg::btf_rgba_s    result_o,
    output btf_pkg::btf_class_e   result_class_o,
    // Store reads
    output btf_pkg::btf_rd_s      rd_o,
    input  logic                  rd_ack_i,
    input  logic [31:0]           rd_data_i
);

    typedef struct packed {
        btf_pkg::btf_bind_s bnd;
        logic               done;
        btf_pkg::btf_err_e  err;
        btf_pkg::btf_fst_e  fsm;
        logic               ready;
        logic               rv;
        btf_pkg::btf_info_s fi;
        logic [1:0]         m;
        btf_pkg::btf_rgba_s res;
        btf_pkg::btf_rd_s   rd;
    } btf_state_s;

    btf_state_s         s_r;
    btf_state_s         s_nxt;
    btf_pkg::btf_info_s a_info;
    btf_pkg::btf_err_e  a_err;
    logic [31:0]        eff_off;
    logic [31:0]        eff_size;
    logic [31:0]        t_raw;
    logic [31:0]        a_cnt;
    logic [31:0]        conv_val;
    logic [31:0]        one_word;
    logic               named;
    logic               misalign;
    logic               bad_val;
    logic               in_range;

    btf_fmt_decode u_decode (
        .fmt_i  (att_cmd_i.fmt),
        .info_o (a_info)
    );

    btf_elem_conv u_conv (
        .raw_i    (rd_data_i),
        .ebytes_i (s_r.fi.ebytes),
        .kind_i   (s_r.fi.kind),
        .val_o    (conv_val)
    );

    // Attach checks
    always_comb begin
        named    = |att_cmd_i.name;
        eff_off  = att_cmd_i.whole ? btf_pkg::ZERO_WORD : att_cmd_i.offset;
        eff_size = att_cmd_i.whole ? att_cmd_i.buf_bytes : att_cmd_i.size;
        misalign = |(eff_off & (btf_pkg::OFFSET_ALIGN - 32'h0000_0001));
        bad_val  = eff_off[31] | eff_size[31] | (eff_size == btf_pkg::ZERO_WORD)
                 | (({1'b0, eff_off} + {1'b0, eff_size}) > {1'b0, att_cmd_i.buf_bytes})
                 | misalign;
        if (!a_info.valid) begin
            a_err = btf_pkg::ERR_BAD_ENUM;
        end else if (named && !att_cmd_i.exists) begin
            a_err = btf_pkg::ERR_BAD_OPERATION;
        end else if (named && bad_val) begin
            a_err = btf_pkg::ERR_BAD_VALUE;
        end else begin
            a_err = btf_pkg::ERR_NONE;
        end
        // Texel bytes is one of 1, 2, 4, 8, 12, 16
        case (a_info.tbytes)
            5'h01:   t_raw = eff_size;
            5'h02:   t_raw = eff_size >> 1;
            5'h04:   t_raw = eff_size >> 2;
            5'h08:   t_raw = eff_size >> 3;
            5'h0C:   t_raw = (eff_size >> 2) / 32'h0000_0003;
            5'h10:   t_raw = eff_size >> 4;
            default: t_raw = btf_pkg::ZERO_WORD;
        endcase
        a_cnt = (t_raw > btf_pkg::MAX_TEXELS) ? btf_pkg::MAX_TEXELS : t_raw;
    end

    // The binding point input is deliberately not used by any state.
    always_comb begin
        in_range = s_r.bnd.attached && !fetch_coord_i[31] && (fetch_coord_i < s_r.bnd.count);
        one_word = (s_r.bnd.info.rclass == btf_pkg::RC_FLOAT) ? btf_pkg::ONE_FLOAT : btf_pkg::ONE_INT;
        s_nxt      = s_r;
        s_nxt.done = 1'b0;
        s_nxt.rv   = 1'b0;
        if (att_valid_i) begin
            s_nxt.done = 1'b1;
            s_nxt.err  = a_err;
            // Any error leaves the attachment as it was
            if (a_err == btf_pkg::ERR_NONE) begin
                s_nxt.bnd.fmt  = att_cmd_i.fmt;
                s_nxt.bnd.info = a_info;
                if (named) begin
                    s_nxt.bnd.attached = 1'b1;
                    s_nxt.bnd.name     = att_cmd_i.name;
                    s_nxt.bnd.offset   = eff_off;
                    s_nxt.bnd.size     = eff_size;
                    s_nxt.bnd.count    = a_cnt;
                end else begin
                    s_nxt.bnd.attached = 1'b0;
                    s_nxt.bnd.name     = btf_pkg::ZERO_WORD;
                    s_nxt.bnd.offset   = btf_pkg::ZERO_WORD;
                    s_nxt.bnd.size     = btf_pkg::ZERO_WORD;
                    s_nxt.bnd.count    = btf_pkg::ZERO_WORD;
                end
            end
        end
        case (s_r.fsm)
            btf_pkg::F_IDLE: begin
                if (fetch_valid_i && s_r.ready) begin
                    // Fetch keeps its own format snapshot; a later attach does not disturb it
                    s_nxt.fi    = s_r.bnd.info;
                    s_nxt.m     = 2'h0;
                    s_nxt.res.c = {one_word, btf_pkg::ZERO_WORD, btf_pkg::ZERO_WORD, btf_pkg::ZERO_WORD};
                    if (in_range) begin
                        s_nxt.rd.req    = 1'b1;
                        s_nxt.rd.addr   = 32'(s_r.bnd.offset + fetch_coord_i * {27'h000_0000, s_r.bnd.info.tbytes});
                        s_nxt.rd.ebytes = s_r.bnd.info.ebytes;
                        s_nxt.fsm       = btf_pkg::F_READ;
                    end else begin
                        // Undefined result: return the fill vector without touching the store
                        s_nxt.fsm = btf_pkg::F_DONE;
                        s_nxt.rv  = 1'b1;
                    end
                end
            end
            btf_pkg::F_READ: begin
                if (rd_ack_i) begin
                    s_nxt.res.c[s_r.m] = conv_val;
                    if ({1'b0, s_r.m} == 3'(s_r.fi.comps - 3'h1)) begin
                        s_nxt.rd.req = 1'b0;
                        s_nxt.fsm    = btf_pkg::F_DONE;
                        s_nxt.rv     = 1'b1;
                    end else begin
                        s_nxt.m       = 2'(s_r.m + 2'h1);
                        s_nxt.rd.addr = 32'(s_r.rd.addr + {29'h0000_0000, s_r.fi.ebytes});
                    end
                end
            end
            btf_pkg::F_DONE: s_nxt.fsm = btf_pkg::F_IDLE;
            default:         s_nxt.fsm = btf_pkg::F_IDLE;
        endcase
        s_nxt.ready = (s_nxt.fsm == btf_pkg::F_IDLE);
    end

    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign att_done_o     = s_r.done;
    assign att_err_o      = s_r.err;
    assign bind_state_o   = s_r.bnd;
    assign fetch_ready_o  = s_r.ready;
    assign result_valid_o = s_r.rv;
    assign result_o       = s_r.res;
    assign result_class_o = s_r.fi.rclass;
    assign rd_o           = s_r.rd;

    property p_detach;
        @(posedge clk_i) disable iff (rst_i)
        att_valid_i && a_info.valid && !named |=>
            !bind_state_o.attached && bind_state_o.offset == 32'h0 && bind_state_o.size == 32'h0;
    endproperty
    a_detach: assert property (p_detach)
        else $error("detach did not clear offset and size");

    property p_bad_enum;
        @(posedge clk_i) disable iff (rst_i)
        att_valid_i && !a_info.valid |=> att_done_o && att_err_o == btf_pkg::ERR_BAD_ENUM;
    endproperty
    a_bad_enum: assert property (p_bad_enum)
        else $error("bad format not flagged");

    property p_bad_op;
        @(posedge clk_i) disable iff (rst_i)
        att_valid_i && a_info.valid && named && !att_cmd_i.exists |=> att_err_o == btf_pkg::ERR_BAD_OPERATION;
    endproperty
    a_bad_op: assert property (p_bad_op)
        else $error("missing store not flagged");

    property p_misalign;
        @(posedge clk_i) disable iff (rst_i)
        att_valid_i && a_info.valid && named && att_cmd_i.exists && !att_cmd_i.whole
            && (att_cmd_i.offset[3:0] != 4'h0) |=> att_err_o == btf_pkg::ERR_BAD_VALUE;
    endproperty
    a_misalign: assert property (p_misalign)
        else $error("misaligned offset accepted");

    property p_whole;
        @(posedge clk_i) disable iff (rst_i)
        att_valid_i && att_cmd_i.whole && named && a_err == btf_pkg::ERR_NONE |=>
            bind_state_o.offset == 32'h0 && bind_state_o.size == $past(att_cmd_i.buf_bytes);
    endproperty
    a_whole: assert property (p_whole)
        else $error("whole attach range wrong");

    property p_keep;
        @(posedge clk_i) disable iff (rst_i)
        att_valid_i && a_err != btf_pkg::ERR_NONE |=> $stable(bind_state_o);
    endproperty
    a_keep: assert property (p_keep)
        else $error("failed attach changed state");

    // Whole texels fit the size with less than one texel left over, unless clamped
    property p_count;
        @(posedge clk_i) disable iff (rst_i)
        att_valid_i && named && a_err == btf_pkg::ERR_NONE |=>
            bind_state_o.count <= btf_pkg::MAX_TEXELS
            && bind_state_o.count * {27'h000_0000, bind_state_o.info.tbytes} <= bind_state_o.size
            && (bind_state_o.count == btf_pkg::MAX_TEXELS
                || bind_state_o.size - bind_state_o.count * {27'h000_0000, bind_state_o.info.tbytes}
                   < {27'h000_0000, bind_state_o.info.tbytes});
    endproperty
    a_count: assert property (p_count)
        else $error("texel count wrong");

    property p_step;
        @(posedge clk_i) disable iff (rst_i)
        s_r.fsm == btf_pkg::F_READ && rd_ack_i && ({1'b0, s_r.m} != 3'(s_r.fi.comps - 3'h1)) |=>
            rd_o.req && rd_o.addr == 32'($past(rd_o.addr) + {29'h0, rd_o.ebytes});
    endproperty
    a_step: assert property (p_step)
        else $error("element address step wrong");

    property p_fill;
        @(posedge clk_i) disable iff (rst_i)
        result_valid_o && s_r.fi.comps != 3'h4 |->
            result_o.c[3] == (result_class_o == btf_pkg::RC_FLOAT ? btf_pkg::ONE_FLOAT : btf_pkg::ONE_INT);
    endproperty
    a_fill: assert property (p_fill)
        else $error("missing alpha not one");

    property p_bind;
        @(posedge clk_i) disable iff (rst_i)
        bind_store_valid_i && bind_store_name_i != 32'h0 && !att_valid_i |=> $stable(bind_state_o);
    endproperty
    a_bind: assert property (p_bind)
        else $error("binding point altered attachment");

    property p_oob;
        @(posedge clk_i) disable iff (rst_i)
        fetch_ready_o && fetch_valid_i && !in_range |=> result_valid_o && !rd_o.req ##1 fetch_ready_o;
    endproperty
    a_oob: assert property (p_oob)
        else $error("out of range fetch not finished");

    property p_hold;
        @(posedge clk_i) disable iff (rst_i)
        rd_o.req && !rd_ack_i |=> rd_o.req && $stable(rd_o.addr) && $stable(rd_o.ebytes);
    endproperty
    a_hold: assert property (p_hold)
        else $error("store request changed before answer");

    property p_three;
        @(posedge clk_i) disable iff (rst_i)
        att_valid_i && a_err == btf_pkg::ERR_NONE && a_info.comps == 3'h3 |=>
            bind_state_o.info.ebytes == 3'h4 && bind_state_o.info.kind != btf_pkg::EK_UNORM
            && bind_state_o.info.kind != btf_pkg::EK_HALF;
    endproperty
    a_three: assert property (p_three)
        else $error("three component format not 32-bit");

    property p_ready;
        @(posedge clk_i) disable iff (rst_i)
        result_valid_o |=> fetch_ready_o && !result_valid_o;
    endproperty
    a_ready: assert property (p_ready)
        else $error("fetch not ready after result");

endmodule

//--- btf_pkg.sv
package btf_pkg;

    // Implementation limits for attach and texel count
    localparam logic [31:0] OFFSET_ALIGN = 32'h0000_0010;
    localparam logic [31:0] MAX_TEXELS   = 32'h0001_0000;

    // Constant words used to fill missing components
    localparam logic [31:0] ONE_FLOAT = 32'h3F80_0000;
    localparam logic [31:0] ONE_INT   = 32'h0000_0001;
    localparam logic [31:0] ZERO_WORD = 32'h0000_0000;

    // First format code of the two-, three- and four-component groups, then the total format count
    localparam logic [5:0] GRP2_BASE = 6'h0A;
    localparam logic [5:0] GRP3_BASE = 6'h14;
    localparam logic [5:0] GRP4_BASE = 6'h17;
    localparam logic [5:0] FMT_COUNT = 6'h21;

    // Float conversion constants
    localparam logic [7:0] HALF_EXP_ADJ = 8'h70;
    localparam logic [7:0] UNORM_EXP    = 8'h7E;
    localparam logic [7:0] EXP_ALL      = 8'hFF;

    typedef enum logic [5:0] {
        FMT_R8, FMT_R16, FMT_R16F, FMT_R32F, FMT_R8I,
        FMT_R16I, FMT_R32I, FMT_R8UI, FMT_R16UI, FMT_R32UI,
        FMT_RG8, FMT_RG16, FMT_RG16F, FMT_RG32F, FMT_RG8I,
        FMT_RG16I, FMT_RG32I, FMT_RG8UI, FMT_RG16UI, FMT_RG32UI,
        THREE_FLOAT_FORMAT, THREE_SIGNED_INT_FORMAT, THREE_UNSIGNED_INT_FORMAT,
        FMT_RGBA8, FMT_RGBA16, FMT_RGBA16F, FMT_RGBA32F, FMT_RGBA8I,
        FMT_RGBA16I, FMT_RGBA32I, FMT_RGBA8UI, FMT_RGBA16UI, FMT_RGBA32UI
    } btf_fmt_e;

    typedef enum logic [2:0] {EK_UNORM, EK_HALF, EK_FLOAT, EK_SINT, EK_UINT} btf_kind_e;
    typedef enum logic [1:0] {RC_FLOAT, RC_SINT, RC_UINT} btf_class_e;
    typedef enum logic [1:0] {ERR_NONE, ERR_BAD_ENUM, ERR_BAD_OPERATION, ERR_BAD_VALUE} btf_err_e;
    typedef enum logic [1:0] {F_IDLE, F_READ, F_DONE} btf_fst_e;

    typedef struct packed {
        logic       valid;
        logic [2:0] comps;
        logic [2:0] ebytes;
        logic [4:0] tbytes;
        btf_kind_e  kind;
        btf_class_e rclass;
    } btf_info_s;

    typedef struct packed {
        logic        whole;
        logic [5:0]  fmt;
        logic [31:0] name;
        logic [31:0] offset;
        logic [31:0] size;
        logic        exists;
        logic [31:0] buf_bytes;
    } btf_att_cmd_s;

    typedef struct packed {
        logic        attached;
        logic [31:0] name;
        logic [31:0] offset;
        logic [31:0] size;
        logic [31:0] count;
        logic [5:0]  fmt;
        btf_info_s   info;
    } btf_bind_s;

    typedef struct packed {
        logic [3:0][31:0] c;
    } btf_rgba_s;

    typedef struct packed {
        logic        req;
        logic [31:0] addr;
        logic [2:0]  ebytes;
    } btf_rd_s;

endpackage

//--- btf_fmt_decode.sv
module btf_fmt_decode (
    // Format code
    input  logic [5:0]         fmt_i,
    // Decoded layout
    output btf_pkg::btf_info_s info_o
);

    logic [5:0] t;
    logic [2:0] c;
    logic [2:0] eb;
    btf_pkg::btf_kind_e k;

    always_comb begin
        c = 3'h0;
        t = 6'h00;
        if (fmt_i < btf_pkg::GRP2_BASE) begin
            c = 3'h1;
            t = fmt_i;
        end else if (fmt_i < btf_pkg::GRP3_BASE) begin
            c = 3'h2;
            t = 6'(fmt_i - btf_pkg::GRP2_BASE);
        end else if (fmt_i < btf_pkg::GRP4_BASE) begin
            // Three components only in the 32-bit variants
            c = 3'h3;
            t = 6'(6'h03 * (fmt_i - btf_pkg::GRP3_BASE) + 6'h03);
        end else if (fmt_i < btf_pkg::FMT_COUNT) begin
            c = 3'h4;
            t = 6'(fmt_i - btf_pkg::GRP4_BASE);
        end
        case (t)
            6'h00:   begin eb = 3'h1; k = btf_pkg::EK_UNORM; end
            6'h01:   begin eb = 3'h2; k = btf_pkg::EK_UNORM; end
            6'h02:   begin eb = 3'h2; k = btf_pkg::EK_HALF;  end
            6'h03:   begin eb = 3'h4; k = btf_pkg::EK_FLOAT; end
            6'h04:   begin eb = 3'h1; k = btf_pkg::EK_SINT;  end
            6'h05:   begin eb = 3'h2; k = btf_pkg::EK_SINT;  end
            6'h06:   begin eb = 3'h4; k = btf_pkg::EK_SINT;  end
            6'h07:   begin eb = 3'h1; k = btf_pkg::EK_UINT;  end
            6'h08:   begin eb = 3'h2; k = btf_pkg::EK_UINT;  end
            default: begin eb = 3'h4; k = btf_pkg::EK_UINT;  end
        endcase
        info_o.valid  = (c != 3'h0);
        info_o.comps  = c;
        info_o.ebytes = eb;
        info_o.tbytes = 5'({2'h0, c} * {2'h0, eb});
        info_o.kind   = k;
        case (k)
            btf_pkg::EK_SINT: info_o.rclass = btf_pkg::RC_SINT;
            btf_pkg::EK_UINT: info_o.rclass = btf_pkg::RC_UINT;
            default:          info_o.rclass = btf_pkg::RC_FLOAT;
        endcase
    end

endmodule

//--- btf_elem_conv.sv
module btf_elem_conv (
    // Raw element, right aligned
    input  logic [31:0]        raw_i,
    input  logic [2:0]         ebytes_i,
    input  btf_pkg::btf_kind_e kind_i,
    // Converted component
    output logic [31:0]        val_o
);

    logic [15:0] vl;
    logic [47:0] rep;
    logic [47:0] sh;
    logic [4:0]  lz;
    logic        narrow;

    always_comb begin
        narrow = (ebytes_i == 3'h1);
        vl     = narrow ? {raw_i[7:0], 8'h00} : raw_i[15:0];
        // v/(2^b-1) in binary is the pattern v repeated
        rep    = narrow ? {6{raw_i[7:0]}} : {3{raw_i[15:0]}};
        lz     = 5'h00;
        for (int i = 0; i < 16; i++) begin
            if (vl[i]) begin
                lz = 5'(15 - i);
            end
        end
        sh = rep << lz;
        case (kind_i)
            btf_pkg::EK_UNORM: begin
                if (vl == 16'h0000) begin
                    val_o = btf_pkg::ZERO_WORD;
                end else if (narrow ? (raw_i[7:0] == 8'hFF) : (raw_i[15:0] == 16'hFFFF)) begin
                    val_o = btf_pkg::ONE_FLOAT;
                end else begin
                    val_o = {1'b0, 8'(btf_pkg::UNORM_EXP - {3'h0, lz}), sh[46:24]};
                end
            end
            btf_pkg::EK_HALF: begin
                // Subnormal halves flush to signed zero
                if (raw_i[14:10] == 5'h00) begin
                    val_o = {raw_i[15], 31'h0000_0000};
                end else if (raw_i[14:10] == 5'h1F) begin
                    val_o = {raw_i[15], btf_pkg::EXP_ALL, raw_i[9:0], 13'h0000};
                end else begin
                    val_o = {raw_i[15], 8'({3'h0, raw_i[14:10]} + btf_pkg::HALF_EXP_ADJ), raw_i[9:0], 13'h0000};
                end
            end
            btf_pkg::EK_SINT: begin
                if (narrow) begin
                    val_o = {{24{raw_i[7]}}, raw_i[7:0]};
                end else if (ebytes_i == 3'h2) begin
                    val_o = {{16{raw_i[15]}}, raw_i[15:0]};
                end else begin
                    val_o = raw_i;
                end
            end
            btf_pkg::EK_UINT: begin
                if (narrow) begin
                    val_o = {24'h00_0000, raw_i[7:0]};
                end else if (ebytes_i == 3'h2) begin
                    val_o = {16'h0000, raw_i[15:0]};
                end else begin
                    val_o = raw_i;
                end
            end
            default: val_o = raw_i;
        endcase
    end

endmodule

//--- btf_store_model.sv
module btf_store_model (
    // Clock and reset
    input  logic             clk_i,
    input  logic             rst_i,
    // Element reads and pacing
    input  btf_pkg::btf_rd_s rd_i,
    input  logic             slow_i,
    // Answers
    output logic             rd_ack_o,
    output logic [31:0]      rd_data_o
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [7:0]  mem [0:255];
    logic [1:0]  wait_r;
    logic [31:0] word;
    logic [31:0] mask;

    // Little-endian store, element right aligned
    always_comb begin
        word = {mem[8'(rd_i.addr + 3)], mem[8'(rd_i.addr + 2)], mem[8'(rd_i.addr + 1)], mem[rd_i.addr[7:0]]};
        mask = (rd_i.ebytes == 3'h1) ? 32'h0000_00FF : (rd_i.ebytes == 3'h2) ? 32'h0000_FFFF : 32'hFFFF_FFFF;
    end

    // Data bus shows garbage outside the acknowledge cycle
    always_ff @(posedge clk_i or posedge rst_i) begin
        if (rst_i) begin
            rd_ack_o  <= 1'b0;
            wait_r    <= 2'h0;
            rd_data_o <= 32'h0000_0000;
        end else if (rd_i.req && !rd_ack_o && wait_r == (slow_i ? 2'h3 : 2'h0)) begin
            rd_ack_o  <= 1'b1;
            wait_r    <= 2'h0;
            rd_data_o <= word & mask;
        end else begin
            rd_ack_o  <= 1'b0;
            rd_data_o <= ~rd_data_o;
            if (rd_i.req && !rd_ack_o) begin
                wait_r <= wait_r + 2'h1;
            end
        end
    end
endmodule

//--- tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic                  clk_i = 1'b0;
    logic                  rst_i = 1'b1;
    logic                  att_valid_i = 1'b0;
    btf_pkg::btf_att_cmd_s cmd = '0;
    logic                  att_done_o;
    btf_pkg::btf_err_e     att_err_o;
    btf_pkg::btf_bind_s    bs;
    logic                  bind_valid = 1'b0;
    logic [31:0]           bind_name = 32'h0;
    logic                  fetch_valid_i = 1'b0;
    logic [31:0]           fetch_coord_i = 32'h0;
    logic                  fetch_ready_o;
    logic                  result_valid_o;
    btf_pkg::btf_rgba_s    res;
    btf_pkg::btf_class_e   res_class;
    btf_pkg::btf_rd_s      rd;
    logic                  rd_ack;
    logic [31:0]           rd_data;
    logic                  slow = 1'b0;
    logic [31:0]           buf_bytes = 32'h40;
    int                    errors = 0;
    int                    n_tests = 0;
    int                    cyc = 0;

    btf_unit u_dut (.clk_i(clk_i), .rst_i(rst_i), .att_valid_i(att_valid_i), .att_cmd_i(cmd),
        .att_done_o(att_done_o), .att_err_o(att_err_o), .bind_state_o(bs), .bind_store_valid_i(bind_valid),
        .bind_store_name_i(bind_name), .fetch_valid_i(fetch_valid_i), .fetch_coord_i(fetch_coord_i),
        .fetch_ready_o(fetch_ready_o), .result_valid_o(result_valid_o), .result_o(res),
        .result_class_o(res_class), .rd_o(rd), .rd_ack_i(rd_ack), .rd_data_i(rd_data));

    btf_store_model u_store (.clk_i(clk_i), .rst_i(rst_i), .rd_i(rd), .slow_i(slow), .rd_ack_o(rd_ack),
        .rd_data_o(rd_data));

    always #4 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            errors++;
            complete_run();
        end
    end

    task automatic tick();
        @(posedge clk_i);
        #1;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // Name 7 never names an existing buffer
    task automatic att(input logic w, input logic [5:0] f, input logic [31:0] nm, input logic [31:0] off,
                       input logic [31:0] sz, input btf_pkg::btf_err_e e);
        cmd = '{w, f, nm, off, sz, nm != 32'h7, buf_bytes};
        att_valid_i = 1'b1;
        tick();
        att_valid_i = 1'b0;
        chk({31'h0, att_done_o}, 32'h1);
        chk({30'h0, att_err_o}, {30'h0, e});
        tick();
        chk({31'h0, att_done_o}, 32'h0);
    endtask

    task automatic fetch(input logic [31:0] n, input logic [31:0] r, g, b, a, input btf_pkg::btf_class_e c);
        for (int k = 0; k < 20 && fetch_ready_o !== 1'b1; k++)
            tick();
        fetch_valid_i = 1'b1;
        fetch_coord_i = n;
        tick();
        fetch_valid_i = 1'b0;
        for (int k = 0; k < 60 && result_valid_o !== 1'b1; k++)
            tick();
        chk({31'h0, result_valid_o}, 32'h1);
        chk(res.c[0], r);
        chk(res.c[1], g);
        chk(res.c[2], b);
        chk(res.c[3], a);
        chk({30'h0, res_class}, {30'h0, c});
    endtask

    task automatic put(input int ad, input logic [31:0] v);
        for (int i = 0; i < 4; i++)
            u_store.mem[ad + i] = v[8*i +: 8];
    endtask

    task automatic sc_errors();
        att(1'b0, btf_pkg::FMT_RG16, 32'h5, 32'h10, 32'h20, btf_pkg::ERR_NONE);
        chk(bs.count, 32'h8);
        att(1'b0, btf_pkg::FMT_COUNT, 32'h7, 32'h10, 32'h20, btf_pkg::ERR_BAD_ENUM);
        att(1'b0, btf_pkg::FMT_R8, 32'h7, 32'h10, 32'h20, btf_pkg::ERR_BAD_OPERATION);
        att(1'b0, btf_pkg::FMT_R8, 32'h5, 32'hFFFF_FFF0, 32'h20, btf_pkg::ERR_BAD_VALUE);
        att(1'b0, btf_pkg::FMT_R8, 32'h5, 32'h10, 32'h0, btf_pkg::ERR_BAD_VALUE);
        att(1'b0, btf_pkg::FMT_R8, 32'h5, 32'h30, 32'h20, btf_pkg::ERR_BAD_VALUE);
        att(1'b0, btf_pkg::FMT_R8, 32'h5, 32'h8, 32'h20, btf_pkg::ERR_BAD_VALUE);
        chk(bs.offset, 32'h10);
        chk({26'h0, bs.fmt}, {26'h0, btf_pkg::FMT_RG16});
    endtask

    task automatic sc_rg16();
        put(20, 32'h0000_FFFF);
        fetch(32'h1, btf_pkg::ONE_FLOAT, 32'h0, 32'h0, btf_pkg::ONE_FLOAT, btf_pkg::RC_FLOAT);
        fetch(32'h8, 32'h0, 32'h0, 32'h0, btf_pkg::ONE_FLOAT, btf_pkg::RC_FLOAT);
        put(20, 32'hFFFF_0000);
        fetch(32'h1, 32'h0, btf_pkg::ONE_FLOAT, 32'h0, btf_pkg::ONE_FLOAT, btf_pkg::RC_FLOAT);
        // Binding the attached name to the load point must change nothing
        bind_name = 32'h5;
        bind_valid = 1'b1;
        tick();
        bind_valid = 1'b0;
        tick();
        chk(bs.size, 32'h20);
        fetch(32'h1, 32'h0, btf_pkg::ONE_FLOAT, 32'h0, btf_pkg::ONE_FLOAT, btf_pkg::RC_FLOAT);
        att(1'b0, btf_pkg::FMT_RG16F, 32'h5, 32'h10, 32'h20, btf_pkg::ERR_NONE);
        put(20, 32'hC000_3E00);
        fetch(32'h1, 32'h3FC0_0000, 32'hC000_0000, 32'h0, btf_pkg::ONE_FLOAT, btf_pkg::RC_FLOAT);
        att(1'b0, btf_pkg::FMT_RG8, 32'h5, 32'h10, 32'h20, btf_pkg::ERR_NONE);
        put(20, 32'h0000_0180);
        fetch(32'h2, 32'h3F00_8080, 32'h3B80_8080, 32'h0, btf_pkg::ONE_FLOAT, btf_pkg::RC_FLOAT);
    endtask

    task automatic sc_whole();
        slow = 1'b1;
        att(1'b1, btf_pkg::FMT_RGBA8I, 32'h5, 32'h10, 32'h8, btf_pkg::ERR_NONE);
        chk(bs.offset, 32'h0);
        chk(bs.size, 32'h40);
        chk(bs.count, 32'h10);
        put(8, 32'hFF01_7F80);
        fetch(32'h2, 32'hFFFF_FF80, 32'h7F, 32'h1, 32'hFFFF_FFFF, btf_pkg::RC_SINT);
        att(1'b0, btf_pkg::THREE_UNSIGNED_INT_FORMAT, 32'h5, 32'h20, 32'h18, btf_pkg::ERR_NONE);
        chk(bs.count, 32'h2);
        put(44, 32'h8000_0001);
        put(48, 32'h1234_5678);
        put(52, 32'hFFFF_FFFE);
        fetch(32'h1, 32'h8000_0001, 32'h1234_5678, 32'hFFFF_FFFE, btf_pkg::ONE_INT, btf_pkg::RC_UINT);
        slow = 1'b0;
    endtask

    task automatic sc_clamp_detach();
        buf_bytes = 32'h2_0000;
        att(1'b0, btf_pkg::FMT_R8, 32'h5, 32'h0, 32'h2_0000, btf_pkg::ERR_NONE);
        chk(bs.count, btf_pkg::MAX_TEXELS);
        att(1'b0, btf_pkg::FMT_R32F, 32'h0, 32'h10, 32'h10, btf_pkg::ERR_NONE);
        chk({31'h0, bs.attached}, 32'h0);
        chk(bs.size, 32'h0);
        fetch(32'h0, 32'h0, 32'h0, 32'h0, btf_pkg::ONE_FLOAT, btf_pkg::RC_FLOAT);
    endtask

    task automatic complete_run();
        $display("Comparisons %0d, mismatches %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    initial begin
        for (int i = 0; i < 256; i++)
            u_store.mem[i] = 8'h00;
        repeat (8) @(posedge clk_i);
        #1;
        rst_i = 1'b0;
        tick();
        sc_errors();
        sc_rg16();
        sc_whole();
        sc_clamp_detach();
        complete_run();
    end
endmodule
